// File: core/tab_pkg.sv
/*
 * tab_pkg: shared constants for the tri-state board bus interface.
 * Assumes a 32-bit address and data system bus on one clock.
 */
package tab_pkg;
    localparam int TAB_ADDR_W = 32;
    localparam int TAB_DATA_W = 32;
    localparam int TAB_NUM_MST = 2;
    localparam int TAB_NUM_SLV = 2;
    localparam int TAB_CTRL_W = 14; // htrans 2, hwrite 1, hsize 3, hburst 3,
                                    // hprot 4, hmastlock 1
    localparam int TAB_CTRL_HWRITE = 2; // hwrite position in control word
    localparam int TAB_CTRL_ACTIVE = 1; // htrans msb: a real transfer
    localparam int TAB_RESP_W = 2;
    localparam logic [TAB_RESP_W-1:0] TAB_RESP_OKAY = 2'h0;
    // slave window: base and mask over the address
    localparam logic [TAB_ADDR_W-1:0] TAB_SLV_BASE = 32'hc000_0000;
    localparam logic [TAB_ADDR_W-1:0] TAB_SLV_MASK = 32'hf000_0000;
    // each slave takes one slice of the window, picked by these bits
    localparam int TAB_SLV_SEL_LSB = 24;
endpackage : tab_pkg

// File: core/tab_bridge.sv
/*
 * tab_bridge: board-side logic joining local bus masters and slaves to a
 * shared tri-state system bus.
 * Assumes one central arbiter on the far side, one system bus clock, and
 * that the board pins resolve the *_o / *_oe_o pairs into wires.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// [R1] each tri-state enable follows the address or data phase it serves
// [R2] master hresp, hready and hrdata come straight from the system bus
// [R3] master address and control drive the bus when granted in address phase
// [R4] master write data drives the data bus in a granted write data phase
// [R5] several masters share one driver set, enabled when any is granted
// [R6] a single system arbiter grants the bus to one master at a time
// [R7] slave address, control and hreadyin come straight from the bus
// [R8] slave write data comes straight from the shared data bus
// [R9] the board decoder spots local slave accesses and enables drivers
// [R10] the decoder also picks which slave's outputs feed the drivers
// [R11] slave hresp and hready drive the bus in the data phase after a selected address phase
// [R12] slave read data drives the data bus in a selected read data phase
// [R13] data bus source is slave read data when hwrite low, else write data
// [R14] the data driver is on only for local master write or slave read
// [R15] all logic runs from the global tile clock carrying the bus clock
// [R16] data-phase qualifiers register grant, select, hwrite when hready high
// [R17] during reset every bus enable stays inactive
module tab_bridge
    import tab_pkg::*;
(
    input wire logic sys_clk_i, // [R15] global tile clock
    input wire logic rst_i, // synchronous, active high
    // arbiter grant, one per local master
    input wire logic [tab_pkg::TAB_NUM_MST-1:0] mst_grant_i, // grant lines
    // local master outputs
    input wire logic [tab_pkg::TAB_NUM_MST-1:0][tab_pkg::TAB_ADDR_W-1:0]
        mst_haddr_i, // master addresses
    input wire logic [tab_pkg::TAB_NUM_MST-1:0][tab_pkg::TAB_CTRL_W-1:0]
        mst_hctrl_i, // master control words
    input wire logic [tab_pkg::TAB_NUM_MST-1:0][tab_pkg::TAB_DATA_W-1:0]
        mst_hwdata_i, // master write data
    // local master inputs
    output logic mst_hready_o, // bus hready to masters
    output logic [tab_pkg::TAB_RESP_W-1:0] mst_hresp_o, // bus hresp
    output logic [tab_pkg::TAB_DATA_W-1:0] mst_hrdata_o, // bus read data
    // local slave inputs
    output logic [tab_pkg::TAB_NUM_SLV-1:0] slv_hsel_o, // slave selects
    output logic [tab_pkg::TAB_ADDR_W-1:0] slv_haddr_o, // bus address
    output logic [tab_pkg::TAB_CTRL_W-1:0] slv_hctrl_o, // bus control
    output logic slv_hreadyin_o, // bus hready
    output logic [tab_pkg::TAB_DATA_W-1:0] slv_hwdata_o, // bus write data
    // local slave outputs
    input wire logic [tab_pkg::TAB_NUM_SLV-1:0] slv_hready_i, // slave readys
    input wire logic [tab_pkg::TAB_NUM_SLV-1:0][tab_pkg::TAB_RESP_W-1:0]
        slv_hresp_i, // slave responses
    input wire logic [tab_pkg::TAB_NUM_SLV-1:0][tab_pkg::TAB_DATA_W-1:0]
        slv_hrdata_i, // slave read data
    // system bus: address and control
    input wire logic [tab_pkg::TAB_ADDR_W-1:0] bus_haddr_i, // address in
    output logic [tab_pkg::TAB_ADDR_W-1:0] bus_haddr_o, // address out
    input wire logic [tab_pkg::TAB_CTRL_W-1:0] bus_hctrl_i, // control in
    output logic [tab_pkg::TAB_CTRL_W-1:0] bus_hctrl_o, // control out
    output logic bus_actrl_oe_o, // address/control enable
    // system bus: response
    input wire logic bus_hready_i, // hready in
    output logic bus_hready_o, // hready out
    input wire logic [tab_pkg::TAB_RESP_W-1:0] bus_hresp_i, // hresp in
    output logic [tab_pkg::TAB_RESP_W-1:0] bus_hresp_o, // hresp out
    output logic bus_resp_oe_o, // response enable
    // shared bidirectional data bus
    input wire logic [tab_pkg::TAB_DATA_W-1:0] shared_bidir_data_bus_i, // in
    output logic [tab_pkg::TAB_DATA_W-1:0] shared_bidir_data_bus_o, // out
    output logic shared_bidir_data_bus_oe_o // data enable
);
    import tab_pkg::*;

    localparam int MW = $clog2(TAB_NUM_MST) > 0 ? $clog2(TAB_NUM_MST) : 1;
    localparam int SW = $clog2(TAB_NUM_SLV) > 0 ? $clog2(TAB_NUM_SLV) : 1;

    logic mgrant_dp_reg, mgrant_dp_next;
    logic ssel_dp_reg, ssel_dp_next;
    logic hwrite_dp_reg, hwrite_dp_next;
    logic [SW-1:0] sidx_dp_reg, sidx_dp_next;
    logic [MW-1:0] midx_dp_reg, midx_dp_next;
    logic any_grant, board_hit;
    logic [MW-1:0] gidx;
    logic [SW-1:0] sidx;

    // address-phase grant and the granted master's index
    always_comb begin
        any_grant = |mst_grant_i; // [R5]
        gidx = '0;
        for (int i = 0; i < TAB_NUM_MST; i++) begin
            if (mst_grant_i[i]) begin
                gidx = MW'(i);
            end
        end
    end

    // board decoder: hit on the window; an address-phase term is gated by
    // htrans so idle cycles never claim the response lines
    always_comb begin
        board_hit = ((bus_haddr_i & TAB_SLV_MASK) == TAB_SLV_BASE)
            && bus_hctrl_i[TAB_CTRL_ACTIVE]; // [R9]
        sidx = bus_haddr_i[TAB_SLV_SEL_LSB +: SW]; // [R10]
        if (int'(sidx) >= TAB_NUM_SLV) begin
            board_hit = 1'b0;
        end
        slv_hsel_o = '0;
        if (board_hit) begin
            slv_hsel_o[sidx] = 1'b1; // [R10]
        end
    end

    // data-phase qualifiers advance only on completed transfers
    always_comb begin
        mgrant_dp_next = mgrant_dp_reg;
        ssel_dp_next = ssel_dp_reg;
        hwrite_dp_next = hwrite_dp_reg;
        sidx_dp_next = sidx_dp_reg;
        midx_dp_next = midx_dp_reg;
        if (bus_hready_i) begin // [R16]
            mgrant_dp_next = any_grant;
            ssel_dp_next = board_hit;
            hwrite_dp_next = bus_hctrl_i[TAB_CTRL_HWRITE];
            sidx_dp_next = sidx;
            midx_dp_next = gidx;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin // [R17]
            mgrant_dp_reg <= 1'b0;
            ssel_dp_reg <= 1'b0;
            hwrite_dp_reg <= 1'b0;
            sidx_dp_reg <= '0;
            midx_dp_reg <= '0;
        end else begin
            mgrant_dp_reg <= mgrant_dp_next;
            ssel_dp_reg <= ssel_dp_next;
            hwrite_dp_reg <= hwrite_dp_next;
            sidx_dp_reg <= sidx_dp_next;
            midx_dp_reg <= midx_dp_next;
        end
    end

    // inputs to local masters and slaves pass straight through; the arbiter
    // guarantees one driver on the wire so no local check is made [R6]
    always_comb begin
        mst_hready_o = bus_hready_i; // [R2]
        mst_hresp_o = bus_hresp_i; // [R2]
        mst_hrdata_o = shared_bidir_data_bus_i; // [R2]
        slv_haddr_o = bus_haddr_i; // [R7]
        slv_hctrl_o = bus_hctrl_i; // [R7]
        slv_hreadyin_o = bus_hready_i; // [R7]
        slv_hwdata_o = shared_bidir_data_bus_i; // [R8]
    end

    // board drivers: muxed sources and phase-timed enables
    always_comb begin
        bus_haddr_o = mst_haddr_i[gidx]; // [R5]
        bus_hctrl_o = mst_hctrl_i[gidx]; // [R5]
        bus_actrl_oe_o = any_grant && !rst_i; // [R3] [R1] [R17]
        // hready belongs to the slave holding the data phase
        bus_hready_o = slv_hready_i[sidx_dp_reg]; // [R11]
        bus_hresp_o = slv_hresp_i[sidx_dp_reg]; // [R11]
        // a selection made in the address phase drives the response lines
        // onward while the data phase of that access runs
        bus_resp_oe_o = ssel_dp_reg && !rst_i; // [R11] [R1] [R17]
        if (!hwrite_dp_reg) begin // [R13]
            shared_bidir_data_bus_o = slv_hrdata_i[sidx_dp_reg]; // [R12]
        end else begin
            shared_bidir_data_bus_o = mst_hwdata_i[midx_dp_reg]; // [R4]
        end
        shared_bidir_data_bus_oe_o = !rst_i
            && ((mgrant_dp_reg && hwrite_dp_reg)
            || (ssel_dp_reg && !hwrite_dp_reg)); // [R14] [R4] [R12]
    end

    // properties guarding the phase timing of every board driver; after a
    // wait state the held qualifiers are covered by a_wait_hold instead
    a_data_oe_cause: assert property ( // [R14]
        @(posedge sys_clk_i) disable iff (rst_i)
        shared_bidir_data_bus_oe_o && $past(bus_hready_i) |->
        ($past(any_grant) && $past(bus_hctrl_i[TAB_CTRL_HWRITE]))
        || ($past(board_hit) && !$past(bus_hctrl_i[TAB_CTRL_HWRITE]))
    ) else $error("data enable without cause");
    a_mst_write_drive: assert property ( // [R4]
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_hready_i && any_grant && bus_hctrl_i[TAB_CTRL_HWRITE]
        |=> shared_bidir_data_bus_oe_o
    ) else $error("master write data not driven");
    a_slv_read_drive: assert property ( // [R12]
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_hready_i && board_hit && !bus_hctrl_i[TAB_CTRL_HWRITE]
        |=> shared_bidir_data_bus_oe_o && !hwrite_dp_reg
    ) else $error("slave read data not driven");
    a_addr_oe_grant: assert property ( // [R3]
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_actrl_oe_o == (|mst_grant_i)
    ) else $error("address enable not tied to grant");
    a_wait_hold: assert property ( // [R16]
        @(posedge sys_clk_i) disable iff (rst_i)
        !bus_hready_i |=> $stable(ssel_dp_reg) && $stable(hwrite_dp_reg)
        && $stable(mgrant_dp_reg)
    ) else $error("data phase moved during wait");
    a_reset_quiet: assert property ( // [R17]
        @(posedge sys_clk_i)
        rst_i |-> !bus_actrl_oe_o && !bus_resp_oe_o
        && !shared_bidir_data_bus_oe_o
    ) else $error("bus driven in reset");
    a_resp_oe_sel: assert property ( // [R11]
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_hready_i && board_hit
        |=> bus_resp_oe_o && (sidx_dp_reg == $past(sidx))
    ) else $error("response not enabled for local slave");
    a_no_idle_drive: assert property ( // [R1]
        @(posedge sys_clk_i) disable iff (rst_i)
        bus_hready_i && !any_grant && !board_hit
        |=> !shared_bidir_data_bus_oe_o && !bus_resp_oe_o
    ) else $error("drive in idle data phase");
    a_sel_onehot: assert property ( // [R10]
        @(posedge sys_clk_i) disable iff (rst_i)
        $onehot0(slv_hsel_o)
    ) else $error("more than one local slave selected");
    a_sel_window: assert property ( // [R9]
        @(posedge sys_clk_i) disable iff (rst_i)
        (|slv_hsel_o) |-> bus_hctrl_i[TAB_CTRL_ACTIVE]
        && ((bus_haddr_i & TAB_SLV_MASK) == TAB_SLV_BASE)
    ) else $error("local slave selected outside its window");
endmodule : tab_bridge

`default_nettype wire

// File: tb/tab_bus_model.sv
/* tab_bus_model: far side of the board bus, with the single arbiter, a
   remote master, a far slave and the resolution of each shared wire.
   Assumes the bench commands the bus owner and the remote values. */
`timescale 1ns/10ps
`default_nettype none
module tab_bus_model (
    input wire logic [1:0] owner_i, // 0 remote, 1 or 2 local master
    input wire logic [31:0] rem_addr_i, // remote address
    input wire logic [13:0] rem_ctrl_i, // remote control
    input wire logic [31:0] rem_data_i, // remote or far data
    input wire logic rem_ready_i, // far slave ready
    input wire logic [31:0] haddr_i, // board address
    input wire logic [13:0] hctrl_i, // board control
    input wire logic actrl_oe_i, // board address enable
    input wire logic hready_i, // board ready
    input wire logic [1:0] hresp_i, // board response
    input wire logic resp_oe_i, // board response enable
    input wire logic [31:0] data_i, // board data
    input wire logic data_oe_i, // board data enable
    output logic [1:0] grant_o, // arbiter grants
    output logic [31:0] bus_haddr_o, // address wire
    output logic [13:0] bus_hctrl_o, // control wire
    output logic bus_hready_o, // ready wire
    output logic [1:0] bus_hresp_o, // response wire
    output logic [31:0] bus_data_o // data wire
);
    // one arbiter for all boards: owner 3 still yields a single grant
    assign grant_o = owner_i & {~owner_i[0], 1'b1};
    // an enabled board driver wins; otherwise the remote party drives,
    // so no wire is ever left floating at a stale value
    assign bus_haddr_o = actrl_oe_i ? haddr_i : rem_addr_i;
    assign bus_hctrl_o = actrl_oe_i ? hctrl_i : rem_ctrl_i;
    assign bus_hready_o = resp_oe_i ? hready_i : rem_ready_i;
    assign bus_hresp_o = resp_oe_i ? hresp_i : 2'h0;
    assign bus_data_o = data_oe_i ? data_i : rem_data_i;
endmodule : tab_bus_model
`default_nettype wire

// File: tb/tab_bridge_bench.sv
/* tab_bridge_bench: directed scenarios for the board bus bridge.
   Assumes tab_bus_model plays arbiter, remote master and far slave. */
`timescale 1ns/10ps
`default_nettype none
module tab_bridge_bench;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rdy = 1'b1;
    logic [1:0] own = 2'h2, g, hsel, sr = 2'h2, m_rsp, b_rsp_o, b_rsp;
    logic [1:0][1:0] sp = 4'h4;
    logic [1:0][31:0] ma = {32'h2000_0040, 32'hd000_0000};
    logic [1:0][31:0] mw = {32'hfeed_0001, 32'h0};
    logic [1:0][31:0] sd = {32'hbbbb_0001, 32'haaaa_0000};
    logic [1:0][13:0] mc = {14'h6, 14'h0};
    logic [31:0] ra = 32'h0, rd = 32'h1234_5678, s_ad, s_wd, m_rd, b_ad_o;
    logic [31:0] b_ad, d_o, b_d;
    logic [13:0] rc = 14'h0, s_ct, b_ct_o, b_ct;
    logic aoe, roe, doe, m_rdy, s_hri, b_rdy_o, b_rdy;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;

    tab_bridge tab_bridge_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .mst_grant_i(g), .mst_haddr_i(ma), .mst_hctrl_i(mc),
        .mst_hwdata_i(mw), .mst_hready_o(m_rdy), .mst_hresp_o(m_rsp),
        .mst_hrdata_o(m_rd), .slv_hsel_o(hsel), .slv_haddr_o(s_ad),
        .slv_hctrl_o(s_ct), .slv_hreadyin_o(s_hri), .slv_hwdata_o(s_wd),
        .slv_hready_i(sr), .slv_hresp_i(sp), .slv_hrdata_i(sd),
        .bus_haddr_i(b_ad), .bus_haddr_o(b_ad_o), .bus_hctrl_i(b_ct),
        .bus_hctrl_o(b_ct_o), .bus_actrl_oe_o(aoe), .bus_hready_i(b_rdy),
        .bus_hready_o(b_rdy_o), .bus_hresp_i(b_rsp), .bus_hresp_o(b_rsp_o),
        .bus_resp_oe_o(roe), .shared_bidir_data_bus_i(b_d),
        .shared_bidir_data_bus_o(d_o), .shared_bidir_data_bus_oe_o(doe));
    tab_bus_model tab_bus_model_i (.owner_i(own), .rem_addr_i(ra),
        .rem_ctrl_i(rc), .rem_data_i(rd), .rem_ready_i(rdy),
        .haddr_i(b_ad_o), .hctrl_i(b_ct_o), .actrl_oe_i(aoe),
        .hready_i(b_rdy_o), .hresp_i(b_rsp_o), .resp_oe_i(roe),
        .data_i(d_o), .data_oe_i(doe), .grant_o(g), .bus_haddr_o(b_ad),
        .bus_hctrl_o(b_ct), .bus_hready_o(b_rdy), .bus_hresp_o(b_rsp),
        .bus_data_o(b_d));

    // clock, and a cycle ceiling well above the seventeen the tests need
    initial forever #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 200) begin
            err_count++;
            results();
        end
    end

    // compare and count; x or z never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // master 1 writes off board, the far slave stalls one data cycle
    task automatic t_mwrite;
        @(posedge sys_clk_i);
        own <= 2'h2;
        #1;
        chk(aoe, 1'b1);
        chk(b_ad_o, ma[1]);
        @(posedge sys_clk_i);
        own <= 2'h0;
        rdy <= 1'b0;
        #1;
        chk({aoe, doe}, 2'h1);
        chk(d_o, mw[1]);
        chk(m_rdy, 1'b0);
        @(posedge sys_clk_i);
        rdy <= 1'b1;
        #1;
        chk(doe, 1'b1);
        @(posedge sys_clk_i);
        #1;
        chk(doe, 1'b0);
        $display("test master write done");
    endtask : t_mwrite

    // remote master reads local slave 1 while slave 0 is not ready
    task automatic t_sread;
        @(posedge sys_clk_i);
        ra <= 32'hc100_0010;
        rc <= 14'h2;
        #1;
        chk(hsel, 2'h2);
        chk(s_ad, 32'hc100_0010);
        @(posedge sys_clk_i);
        rc <= 14'h0;
        #1;
        chk({roe, doe, b_rdy_o}, 3'h7);
        chk(b_rsp_o, 2'h1);
        chk(d_o, sd[1]);
        chk(m_rd, sd[1]);
        chk(m_rsp, 2'h1);
        @(posedge sys_clk_i);
        #1;
        chk({roe, doe}, 2'h0);
        $display("test slave read done");
    endtask : t_sread

    // remote master writes local slave 0: board data driver stays off
    task automatic t_swrite;
        @(posedge sys_clk_i);
        ra <= 32'hc000_0020;
        rc <= 14'h6;
        sr <= 2'h1; // slave 0 ready now, slave 1 stalled
        #1;
        chk(hsel, 2'h1);
        chk(s_ct, 14'h6);
        @(posedge sys_clk_i);
        rc <= 14'h0;
        rd <= 32'h5555_aaaa;
        #1;
        chk({roe, doe, s_hri}, 3'h5);
        chk(b_rsp_o, sp[0]);
        chk(s_wd, 32'h5555_aaaa);
        $display("test slave write done");
    endtask : t_swrite

    // master 0 reads just past the slave window
    task automatic t_mread;
        @(posedge sys_clk_i);
        own <= 2'h1;
        mc[0] <= 14'h2;
        #1;
        chk({aoe, hsel}, 3'h4);
        chk(b_ct_o, 14'h2);
        chk(b_ad_o, ma[0]);
        @(posedge sys_clk_i);
        own <= 2'h0;
        rd <= 32'h0bad_f00d;
        #1;
        chk(doe, 1'b0);
        chk(m_rd, 32'h0bad_f00d);
        $display("test master read done");
    endtask : t_mread

    // reset cut into a granted write while the bus waits: drivers drop at
    // once and the held data phase is cleared, not carried past reset
    task automatic t_reset;
        @(posedge sys_clk_i);
        own <= 2'h2;
        @(posedge sys_clk_i);
        own <= 2'h0;
        rst_i <= 1'b1;
        rdy <= 1'b0;
        #1;
        chk({aoe, roe, doe}, 3'h0);
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdy <= 1'b1;
        #1;
        chk(doe, 1'b0);
        $display("test mid reset done");
    endtask : t_reset

    // verdict and end of run
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // reset for three cycles with a write request pending, then the tests
    initial begin
        @(posedge sys_clk_i);
        #1;
        chk({aoe, roe, doe}, 3'h0);
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        own <= 2'h0;
        t_mwrite();
        t_sread();
        t_swrite();
        t_mread();
        t_reset();
        results();
    end
endmodule : tab_bridge_bench
`default_nettype wire
